// ===== bench/dbg_key_checker.sv
`timescale 1ns/10ps
`default_nettype none
module dbg_key_checker (
   input wire logic        CLK_SYS_I, RST_N_I, AWVALID_I, WVALID_I, AWREADY_O, BVALID_O,
   input wire logic        BREADY_I, ARVALID_I, ARREADY_O, RVALID_O, RREADY_I, CMD_VALID_I,
   input wire logic        CMD_READY_O, TX_VALID_O, TX_READY_I, SYSBUS_REQ_I, NVM_LOCKED_I,
   input wire logic        SYSBUS_GRANT_O, SYSBUS_DENY_O, ERASE_START_O, NVM_PROG_EN_O,
   input wire logic        USER_ROW_EN_O, USER_ROW_PROG_READY_I, NVM_PROG_READY_I,
   input wire logic [1:0]  CMD_KIND_I,
   input wire logic [7:0]  CMD_SIZE_I, TX_DATA_O,
   input wire logic [31:0] RDATA_O
);
   // ==========================================================
   // Checks
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!RST_N_I);
   chk_lock_deny:
      assert property (SYSBUS_REQ_I |-> SYSBUS_DENY_O == NVM_LOCKED_I
         && SYSBUS_GRANT_O == !NVM_LOCKED_I) else $error("bus access vs lock");
   chk_write_resp:
      assert property (AWVALID_I && WVALID_I && AWREADY_O |=> BVALID_O) else $error("no bvalid");
   chk_bresp_hold:
      assert property (BVALID_O && !BREADY_I |=> BVALID_O) else $error("bvalid dropped");
   chk_read_hold:
      assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
         else $error("read data unstable");
   chk_tx_hold:
      assert property (TX_VALID_O && !TX_READY_I |=> TX_VALID_O && $stable(TX_DATA_O))
         else $error("tx byte unstable");
   chk_info_delay:
      assert property (CMD_VALID_I && CMD_READY_O && CMD_KIND_I == 2'h2 && CMD_SIZE_I != 8'h00
         |-> ##2 TX_VALID_O) else $error("info byte late");
   chk_key_silent:
      assert property (CMD_VALID_I && CMD_READY_O && CMD_KIND_I == 2'h1 |=> !TX_VALID_O [*8])
         else $error("reply after key");
   chk_erase_pulse:
      assert property (ERASE_START_O |=> !ERASE_START_O) else $error("erase pulse long");
   chk_nvm_gate:
      assert property (NVM_PROG_EN_O |-> !NVM_LOCKED_I && NVM_PROG_READY_I)
         else $error("nvm enable ungated");
   chk_urow_gate:
      assert property (USER_ROW_EN_O |-> NVM_LOCKED_I && USER_ROW_PROG_READY_I)
         else $error("user row enable ungated");
endmodule : dbg_key_checker
bind debug_key_sib_erase_logic dbg_key_checker dbg_key_checker_inst (.*);
`default_nettype wire

// ===== bench/dbg_link_model.sv
`timescale 1ns/10ps
`default_nettype none
module dbg_link_model (
   input wire logic       clk_i,
   input wire logic       rst_n_i,
   input wire logic       valid_i,
   input wire logic [7:0] data_i,
   input wire logic [3:0] gap_i,
   input wire logic       slow_i,
   output logic           ready_o
);
   logic [7:0] q_data[$];
   logic [3:0] q_gap[$];
   // Slow mode stalls every other cycle
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) ready_o <= 1'b0;
      else begin
         if (valid_i && ready_o) begin
            q_data.push_back(data_i);
            q_gap.push_back(gap_i);
         end
         ready_o <= slow_i ? !ready_o : 1'b1;
      end
   end
endmodule : dbg_link_model
`default_nettype wire

// ===== bench/test_debug_key_sib_erase_logic.sv
`timescale 1ns/10ps
`default_nettype none
module test_debug_key_sib_erase_logic;
   import dbg_key_pkg::*;
   localparam logic [55:0] FAM = 56'h41424344454647;
   localparam logic [23:0] NVR = 24'h313233, DBR = 24'h343536;
   localparam logic [127:0] SIB = {8'h37, 8'h20, DBR, NVR, 8'h20, FAM};
   localparam logic [63:0] KE = 64'h4e564d4572617365, KN = 64'h4e564d50726f6720;
   localparam logic [63:0] KU = 64'h4e564d5573267465;
   logic CLK_SYS_I = 0, RST_N_I = 0, AWVALID_I = 0, WVALID_I = 0, BREADY_I = 0, ARVALID_I = 0;
   logic RREADY_I = 0, CMD_VALID_I = 0, RX_VALID_I = 0, LD_VALID_I = 0, PORT_DISABLE_I = 0;
   logic NVM_LOCKED_I = 1, NVM_PROG_READY_I = 0, USER_ROW_PROG_READY_I = 0, PROG_DONE_I = 0;
   logic SYSBUS_REQ_I = 0, slow = 0, TX_READY_I;
   logic [3:0] AWADDR_I = 0, ARADDR_I = 0, WSTRB_I = 4'hf, TX_GAP_O;
   logic [31:0] WDATA_I = 0, RDATA_O;
   logic [7:0] CMD_SIZE_I = 0, REPEAT_I = 0, RX_DATA_I = 0, LD_DATA_I = 0, TX_DATA_O;
   logic [1:0] CMD_KIND_I = 0, BRESP_O, RRESP_O;
   logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, CMD_READY_O, LD_READY_O, TX_VALID_O;
   logic SYSBUS_GRANT_O, SYSBUS_DENY_O, SYS_RESET_O, ERASE_START_O, NVM_PROG_EN_O, USER_ROW_EN_O;
   int err_total = 0, comparisons = 0, erases = 0;
   debug_key_sib_erase_logic #(.FAMILY_IDENTIFIER(FAM), .NVM_REVISION(NVR), .DEBUG_REVISION(DBR),
      .OSC_FREQUENCY(8'h37), .RESET_SIGNATURE(8'h5a)) debug_key_sib_erase_logic_inst (.*);
   dbg_link_model dbg_link_model_inst (.clk_i(CLK_SYS_I), .rst_n_i(RST_N_I),
      .valid_i(TX_VALID_O), .data_i(TX_DATA_O), .gap_i(TX_GAP_O), .slow_i(slow),
      .ready_o(TX_READY_I));
   always #10 CLK_SYS_I = ~CLK_SYS_I;
   always @(posedge CLK_SYS_I) if (ERASE_START_O === 1'b1) erases++;
   // ==========================================================
   // Shared tasks
   task automatic chk(input string n, input logic [31:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
      end
   endtask : chk
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : summarize
   task automatic tick(input int n = 1);
      repeat (n) @(posedge CLK_SYS_I);
   endtask : tick
   task automatic waitfor(ref logic s);
      int k = 0;
      do begin
         tick();
         if (++k > 300) begin
            chk("timeout", 0, 1);
            summarize();
         end
      end while (s !== 1'b1);
   endtask : waitfor
   task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] e = RESP_OKAY);
      AWADDR_I <= a;
      WDATA_I <= {24'h0, d};
      AWVALID_I <= 1'b1;
      WVALID_I <= 1'b1;
      BREADY_I <= 1'b1;
      waitfor(AWREADY_O);
      chk("wready", WREADY_O, 1'b1);
      AWVALID_I <= 1'b0;
      WVALID_I <= 1'b0;
      waitfor(BVALID_O);
      chk("bresp", BRESP_O, e);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] d, input logic [1:0] e = RESP_OKAY);
      ARADDR_I <= a;
      ARVALID_I <= 1'b1;
      RREADY_I <= 1'b1;
      waitfor(ARREADY_O);
      ARVALID_I <= 1'b0;
      waitfor(RVALID_O);
      chk("rdata", RDATA_O, {24'h0, d});
      chk("rresp", RRESP_O, e);
   endtask : rd
   task automatic cmd(input logic [1:0] k, input logic [7:0] sz, input logic [7:0] rp = 8'h00);
      CMD_KIND_I <= k;
      CMD_SIZE_I <= sz;
      REPEAT_I <= rp;
      CMD_VALID_I <= 1'b1;
      waitfor(CMD_READY_O);
      CMD_VALID_I <= 1'b0;
   endtask : cmd
   task automatic key(input logic [63:0] s, input logic [7:0] n = 8'h08);
      cmd(2'h1, n);
      for (int i = 0; i < n; i++) begin
         RX_DATA_I <= s[8*i+:8];
         RX_VALID_I <= 1'b1;
         tick();
         RX_VALID_I <= 1'b0;
         tick();
      end
      tick(3);
   endtask : key
   task automatic rx_chk(input int n, input logic [3:0] g0, g, input bit sib);
      chk("count", dbg_link_model_inst.q_data.size(), n);
      foreach (dbg_link_model_inst.q_data[i]) begin
         chk("byte", dbg_link_model_inst.q_data[i], sib ? SIB[8*i+:8] : 8'h40 + i);
         chk("gap", dbg_link_model_inst.q_gap[i], i ? g : g0);
         if (sib) chk("ascii", dbg_link_model_inst.q_data[i][7], 1'b0);
      end
      dbg_link_model_inst.q_data.delete();
      dbg_link_model_inst.q_gap.delete();
   endtask : rx_chk
   // ==========================================================
   // Scenarios
   task automatic info(input logic [7:0] sz, input int n, input logic [3:0] g0, g);
      cmd(2'h2, sz);
      tick(100);
      rx_chk(n, g0, g, 1);
   endtask : info
   task automatic idle_cmds;
      cmd(2'h0, 8'h04);
      tick();
      cmd(2'h2, 8'h00);
      tick(10);
      rx_chk(0, 4'h0, 4'h0, 1);
   endtask : idle_cmds
   task automatic load;
      LD_VALID_I <= 1'b1;
      LD_DATA_I <= 8'h40;
      cmd(2'h3, 8'h02, 8'h02);
      repeat (60) begin
         tick();
         if (LD_READY_O === 1'b1) LD_DATA_I <= LD_DATA_I + 8'h01;
      end
      LD_VALID_I <= 1'b0;
      rx_chk(6, 4'h5, 4'h4, 0);
   endtask : load
   task automatic keys;
      // Leaves the low erase byte on top so a short key would complete the signature
      key({KE[7:0], KE[55:0]});
      key(KE >> 8, 8'h07);
      key({<<8{KE}});
      rd(4'h4, 8'h00);
   endtask : keys
   task automatic erase;
      key(KE);
      rd(4'h4, 8'h08);
      wr(4'h8, 8'h5a);
      tick(4);
      chk("reset", SYS_RESET_O, 1'b1);
      rd(4'hc, 8'h21);
      chk("erase", erases, 0);
      wr(4'h8, 8'h00);
      tick(4);
      chk("erase", erases, 1);
      chk("reset", SYS_RESET_O, 1'b0);
      NVM_LOCKED_I <= 1'b0;
      rd(4'hc, 8'h00);
   endtask : erase
   task automatic progkeys;
      NVM_PROG_READY_I <= 1'b1;
      SYSBUS_REQ_I <= 1'b1;
      key(KN);
      chk("grant", SYSBUS_GRANT_O, 1'b1);
      chk("nvm", NVM_PROG_EN_O, 1'b1);
      rd(4'h4, 8'h18);
      PROG_DONE_I <= 1'b1;
      tick();
      PROG_DONE_I <= 1'b0;
      tick(3);
      chk("nvm", NVM_PROG_EN_O, 1'b0);
      NVM_LOCKED_I <= 1'b1;
      USER_ROW_PROG_READY_I <= 1'b1;
      key(KU);
      chk("deny", SYSBUS_DENY_O, 1'b1);
      rd(4'hc, 8'h05);
      wr(4'h4, 8'h20);
      rd(4'h4, 8'h08);
      PORT_DISABLE_I <= 1'b1;
      tick();
      PORT_DISABLE_I <= 1'b0;
      rd(4'h4, 8'h00);
   endtask : progkeys
   initial begin
      tick(10);
      RST_N_I <= 1'b1;
      tick();
      rd(4'h0, 8'h02);
      rd(4'hc, 8'h01);
      rd(4'h2, 8'h00, RESP_SLVERR);
      info(8'h10, 16, 4'h2, 4'h2);
      info(8'h08, 8, 4'h2, 4'h2);
      idle_cmds();
      wr(4'h0, 8'h85);
      rd(4'h0, 8'h85);
      slow <= 1'b1;
      info(8'h14, 16, 4'h5, 4'h4);
      load();
      slow <= 1'b0;
      keys();
      erase();
      progkeys();
      summarize();
   end
endmodule : test_debug_key_sib_erase_logic
`default_nettype wire

// ===== rtl/dbg_key_pkg.sv
`default_nettype none
package dbg_key_pkg;
   // ==========================================================
   // Register map (byte addresses)
   localparam logic [3:0] OFS_CTRL        = 4'h0;
   localparam logic [3:0] OFS_KEY_STATUS  = 4'h4;
   localparam logic [3:0] OFS_RESET_REQ   = 4'h8;
   localparam logic [3:0] OFS_SYS_STATUS  = 4'hc;
   localparam logic [1:0] RESP_OKAY       = 2'h0;
   localparam logic [1:0] RESP_SLVERR     = 2'h2;
   // ==========================================================
   // Field positions
   localparam int CTRL_GAP_BIT    = 7;
   localparam int CTRL_GUARD_LSB  = 0;
   localparam int KEY_UROW_BIT    = 5;
   localparam int KEY_NVM_BIT     = 4;
   localparam int KEY_ERASE_BIT   = 3;
   localparam int SYS_LOCKED_BIT  = 0;
   localparam int SYS_UROW_BIT    = 2;
   localparam int SYS_NVM_BIT     = 3;
   localparam int SYS_RESET_BIT   = 5;
   localparam logic [7:0] CTRL_RESET     = 8'h02;
   localparam logic [7:0] RESET_REQUEST_FIELD_CLEAR   = 8'h00;
   // ==========================================================
   // Serial framing
   localparam logic [3:0] IDLE_BITS      = 4'h2;
   localparam logic [3:0] GAP_EXTRA_BITS = 4'h2;
   localparam logic [7:0] KEY_BYTES      = 8'h08;
   localparam logic [7:0] INFO_BYTES_MAX = 8'h10;
   localparam int         NUM_KEYS       = 3;
   localparam int         KEY_ERASE      = 0;
   localparam int         KEY_NVM        = 1;
   localparam int         KEY_UROW       = 2;
   localparam logic [NUM_KEYS-1:0][63:0] KEY_SIGS = {
      64'h4e564d5573267465,
      64'h4e564d50726f6720,
      64'h4e564d4572617365
   };
   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      CMD_NONE     = 2'b00,
      CMD_KEY_SEND = 2'b01,
      CMD_INFO_RD  = 2'b10,
      CMD_LOAD     = 2'b11
   } cmd_e;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_KEY  = 2'b01,
      ST_INFO = 2'b10,
      ST_LOAD = 2'b11
   } state_e;
   typedef struct packed {
      logic [7:0] data;
      logic [3:0] gap;
   } tx_beat_s;
endpackage : dbg_key_pkg
`default_nettype wire

// ===== rtl/debug_key_sib_erase_logic.sv
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module debug_key_sib_erase_logic
   import dbg_key_pkg::*;
#(
   parameter logic [55:0] FAMILY_IDENTIFIER      = 56'h44454d4f46414d,  // Arbitrary value
   parameter logic [23:0] NVM_REVISION   = 24'h503a30,          // Arbitrary value
   parameter logic [23:0] DEBUG_REVISION = 24'h443a30,          // Arbitrary value
   parameter logic [7:0]  OSC_FREQUENCY  = 8'h33,               // Arbitrary value
   parameter logic [7:0]  RESET_SIGNATURE = 8'h5a
)(
   input  wire logic        CLK_SYS_I,
   input  wire logic        RST_N_I,
   // AXI4-Lite slave
   input  wire logic [3:0]  AWADDR_I,
   input  wire logic        AWVALID_I,
   output logic             AWREADY_O,
   input  wire logic [31:0] WDATA_I,
   input  wire logic [3:0]  WSTRB_I,
   input  wire logic        WVALID_I,
   output logic             WREADY_O,
   output logic [1:0]       BRESP_O,
   output logic             BVALID_O,
   input  wire logic        BREADY_I,
   input  wire logic [3:0]  ARADDR_I,
   input  wire logic        ARVALID_I,
   output logic             ARREADY_O,
   output logic [31:0]      RDATA_O,
   output logic [1:0]       RRESP_O,
   output logic             RVALID_O,
   input  wire logic        RREADY_I,
   // Decoded instruction and receive byte stream
   input  wire logic        CMD_VALID_I,
   input  wire logic [1:0]  CMD_KIND_I,
   input  wire logic [7:0]  CMD_SIZE_I,
   input  wire logic [7:0]  REPEAT_I,
   output logic             CMD_READY_O,
   input  wire logic        RX_VALID_I,
   input  wire logic [7:0]  RX_DATA_I,
   // Load data from the bus side
   input  wire logic        LD_VALID_I,
   input  wire logic [7:0]  LD_DATA_I,
   output logic             LD_READY_O,
   // Transmit byte stream
   output logic             TX_VALID_O,
   output logic [7:0]       TX_DATA_O,
   output logic [3:0]       TX_GAP_O,
   input  wire logic        TX_READY_I,
   // System side
   input  wire logic        PORT_DISABLE_I,
   input  wire logic        NVM_LOCKED_I,
   input  wire logic        NVM_PROG_READY_I,
   input  wire logic        USER_ROW_PROG_READY_I,
   input  wire logic        PROG_DONE_I,
   input  wire logic        SYSBUS_REQ_I,
   output logic             SYSBUS_GRANT_O,
   output logic             SYSBUS_DENY_O,
   output logic             SYS_RESET_O,
   output logic             ERASE_START_O,
   output logic             NVM_PROG_EN_O,
   output logic             USER_ROW_EN_O
);
   // ==========================================================
   // Information block image, byte 0 first
   localparam logic [127:0] INFO_IMAGE = {
      OSC_FREQUENCY, 8'h20, DEBUG_REVISION, NVM_REVISION, 8'h20, FAMILY_IDENTIFIER
   };

   // ==========================================================
   // State
   state_e      state_r, state_nxt;
   logic [7:0]  size_r, size_nxt;
   logic [7:0]  cnt_r, cnt_nxt;
   logic [7:0]  rpt_r, rpt_nxt;
   logic        first_r, first_nxt;
   logic        key_chk_r, key_chk_nxt;
   tx_beat_s    beat_r, beat_nxt;
   logic        txv_r, txv_nxt;
   logic        erase_key_active_r, erase_key_active_nxt;
   logic        nvm_program_key_r, nvm_program_key_nxt;
   logic        user_row_write_key_r, user_row_write_key_nxt;
   logic        sys_reset_r, sys_reset_nxt;
   logic        erase_start_r, erase_start_nxt;
   logic [7:0]  ctrl_r, ctrl_nxt;
   logic [7:0]  reset_request_reg_r, reset_request_reg_nxt;
   logic        bvalid_r, bvalid_nxt;
   logic [1:0]  bresp_r, bresp_nxt;
   logic        rvalid_r, rvalid_nxt;
   logic [1:0]  rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;

   logic [NUM_KEYS-1:0] key_match;
   logic [3:0]  gap;
   logic        slot_free;
   logic        wr_take;
   logic        rd_take;
   logic        key_status_wr;
   logic [7:0]  key_status_reg;
   logic [7:0]  system_status_reg;
   logic [7:0]  info_byte;
   logic        interbyte_gap_enable;

   assign interbyte_gap_enable = ctrl_r[CTRL_GAP_BIT];
   assign slot_free = !txv_r || TX_READY_I;
   assign info_byte = INFO_IMAGE[{cnt_r[3:0], 3'h0} +: 8];

   key_matcher key_matcher_inst (
      .clk_i        (CLK_SYS_I),
      .rst_n_i      (RST_N_I),
      .byte_valid_i (RX_VALID_I && (state_r == ST_KEY)),
      .byte_i       (RX_DATA_I),
      .match_o      (key_match)
   );

   gap_select gap_select_inst (
      .first_i  (first_r),
      .gap_en_i (interbyte_gap_enable),
      .guard_i  (ctrl_r[CTRL_GUARD_LSB +: 4]),
      .gap_o    (gap)
   );

   // ==========================================================
   // Instruction sequencer
   always_comb begin
      state_nxt   = state_r;
      size_nxt    = size_r;
      cnt_nxt     = cnt_r;
      rpt_nxt     = rpt_r;
      first_nxt   = first_r;
      key_chk_nxt = 1'b0;
      beat_nxt    = beat_r;
      txv_nxt     = txv_r && !TX_READY_I;
      CMD_READY_O = (state_r == ST_IDLE) && !txv_r;
      LD_READY_O  = (state_r == ST_LOAD) && slot_free;
      case (state_r)
         ST_IDLE: begin
            if (CMD_VALID_I && CMD_READY_O) begin
               size_nxt  = CMD_SIZE_I;
               cnt_nxt   = 8'h0;
               rpt_nxt   = REPEAT_I;
               first_nxt = 1'b1;
               case (cmd_e'(CMD_KIND_I))
                  CMD_KEY_SEND: state_nxt = ST_KEY;
                  CMD_INFO_RD: begin
                     state_nxt = ST_INFO;
                     if (CMD_SIZE_I > INFO_BYTES_MAX) begin
                        size_nxt = INFO_BYTES_MAX;
                     end
                  end
                  CMD_LOAD: state_nxt = ST_LOAD;
                  default: state_nxt = ST_IDLE;
               endcase
               if (CMD_SIZE_I == 8'h0) begin
                  state_nxt = ST_IDLE;
               end
            end
         end
         ST_KEY: begin
            if (RX_VALID_I) begin
               cnt_nxt = cnt_r + 8'h1;
               if (cnt_nxt == size_r) begin
                  key_chk_nxt = (size_r == KEY_BYTES);
                  state_nxt   = ST_IDLE;
               end
            end
         end
         ST_INFO: begin
            if (slot_free) begin
               beat_nxt.data = info_byte;
               beat_nxt.gap  = gap;
               txv_nxt       = 1'b1;
               first_nxt     = 1'b0;
               cnt_nxt       = cnt_r + 8'h1;
               if (cnt_nxt == size_r) begin
                  state_nxt = ST_IDLE;
               end
            end
         end
         ST_LOAD: begin
            if (LD_VALID_I && LD_READY_O) begin
               beat_nxt.data = LD_DATA_I;
               beat_nxt.gap  = gap;
               txv_nxt       = 1'b1;
               first_nxt     = 1'b0;
               cnt_nxt       = cnt_r + 8'h1;
               if (cnt_nxt == size_r) begin
                  cnt_nxt = 8'h0;
                  if (rpt_r == 8'h0) begin
                     state_nxt = ST_IDLE;
                  end else begin
                     rpt_nxt = rpt_r - 8'h1;
                  end
               end
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state_r   <= ST_IDLE;
         size_r    <= 8'h0;
         cnt_r     <= 8'h0;
         rpt_r     <= 8'h0;
         first_r   <= 1'b0;
         key_chk_r <= 1'b0;
         beat_r    <= '0;
         txv_r     <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         size_r    <= size_nxt;
         cnt_r     <= cnt_nxt;
         rpt_r     <= rpt_nxt;
         first_r   <= first_nxt;
         key_chk_r <= key_chk_nxt;
         beat_r    <= beat_nxt;
         txv_r     <= txv_nxt;
      end
   end

   // ==========================================================
   // Keys, reset request and erase
   always_comb begin
      erase_key_active_nxt   = erase_key_active_r;
      nvm_program_key_nxt    = nvm_program_key_r;
      user_row_write_key_nxt = user_row_write_key_r;
      if (key_chk_r && key_match[KEY_ERASE]) begin
         erase_key_active_nxt = 1'b1;
      end else if (PORT_DISABLE_I) begin
         erase_key_active_nxt = 1'b0;
      end
      if (key_chk_r && key_match[KEY_NVM]) begin
         nvm_program_key_nxt = 1'b1;
      end else if (PROG_DONE_I) begin
         nvm_program_key_nxt = 1'b0;
      end
      if (key_chk_r && key_match[KEY_UROW]) begin
         user_row_write_key_nxt = 1'b1;
      end else if (key_status_wr && WDATA_I[KEY_UROW_BIT]) begin
         user_row_write_key_nxt = 1'b0;
      end
      sys_reset_nxt = sys_reset_r;
      if (wr_take && (AWADDR_I == OFS_RESET_REQ) && WSTRB_I[0]) begin
         if (WDATA_I[7:0] == RESET_SIGNATURE) begin
            sys_reset_nxt = 1'b1;
         end else if (WDATA_I[7:0] == RESET_REQUEST_FIELD_CLEAR) begin
            sys_reset_nxt = 1'b0;
         end
      end
      // Erase begins as the system leaves the requested reset
      erase_start_nxt = sys_reset_r && !sys_reset_nxt && erase_key_active_r;
   end

   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         erase_key_active_r   <= 1'b0;
         nvm_program_key_r    <= 1'b0;
         user_row_write_key_r <= 1'b0;
         sys_reset_r          <= 1'b0;
         erase_start_r        <= 1'b0;
      end else begin
         erase_key_active_r   <= erase_key_active_nxt;
         nvm_program_key_r    <= nvm_program_key_nxt;
         user_row_write_key_r <= user_row_write_key_nxt;
         sys_reset_r          <= sys_reset_nxt;
         erase_start_r        <= erase_start_nxt;
      end
   end

   // ==========================================================
   // Register bus slave
   assign wr_take       = AWVALID_I && WVALID_I && !bvalid_r;
   assign rd_take       = ARVALID_I && !rvalid_r;
   assign key_status_wr = wr_take && (AWADDR_I == OFS_KEY_STATUS) && WSTRB_I[0];

   always_comb begin
      key_status_reg = 8'h0;
      key_status_reg[KEY_ERASE_BIT] = erase_key_active_r;
      key_status_reg[KEY_NVM_BIT]   = nvm_program_key_r;
      key_status_reg[KEY_UROW_BIT]  = user_row_write_key_r;
      system_status_reg = 8'h0;
      system_status_reg[SYS_LOCKED_BIT] = NVM_LOCKED_I;
      system_status_reg[SYS_NVM_BIT]    = NVM_PROG_EN_O;
      system_status_reg[SYS_UROW_BIT]   = USER_ROW_EN_O;
      system_status_reg[SYS_RESET_BIT]  = sys_reset_r;
   end

   always_comb begin
      ctrl_nxt              = ctrl_r;
      reset_request_reg_nxt = reset_request_reg_r;
      bvalid_nxt            = bvalid_r && !BREADY_I;
      bresp_nxt             = bresp_r;
      rvalid_nxt            = rvalid_r && !RREADY_I;
      rresp_nxt             = rresp_r;
      rdata_nxt             = rdata_r;
      if (wr_take) begin
         bvalid_nxt = 1'b1;
         bresp_nxt  = RESP_OKAY;
         case (AWADDR_I)
            OFS_CTRL: begin
               if (WSTRB_I[0]) begin
                  ctrl_nxt = WDATA_I[7:0];
               end
            end
            OFS_RESET_REQ: begin
               if (WSTRB_I[0]) begin
                  reset_request_reg_nxt = WDATA_I[7:0];
               end
            end
            OFS_KEY_STATUS: bresp_nxt = RESP_OKAY;
            OFS_SYS_STATUS: bresp_nxt = RESP_OKAY;
            default: bresp_nxt = RESP_SLVERR;
         endcase
      end
      if (rd_take) begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = RESP_OKAY;
         case (ARADDR_I)
            OFS_CTRL:       rdata_nxt = {24'h0, ctrl_r};
            OFS_KEY_STATUS: rdata_nxt = {24'h0, key_status_reg};
            OFS_RESET_REQ:  rdata_nxt = {24'h0, reset_request_reg_r};
            OFS_SYS_STATUS: rdata_nxt = {24'h0, system_status_reg};
            default: begin
               rdata_nxt = 32'h0;
               rresp_nxt = RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ctrl_r              <= CTRL_RESET;
         reset_request_reg_r <= RESET_REQUEST_FIELD_CLEAR;
         bvalid_r            <= 1'b0;
         bresp_r             <= RESP_OKAY;
         rvalid_r            <= 1'b0;
         rresp_r             <= RESP_OKAY;
         rdata_r             <= 32'h0;
      end else begin
         ctrl_r              <= ctrl_nxt;
         reset_request_reg_r <= reset_request_reg_nxt;
         bvalid_r            <= bvalid_nxt;
         bresp_r             <= bresp_nxt;
         rvalid_r            <= rvalid_nxt;
         rresp_r             <= rresp_nxt;
         rdata_r             <= rdata_nxt;
      end
   end

   // ==========================================================
   // Outputs
   assign AWREADY_O      = wr_take;
   assign WREADY_O       = wr_take;
   assign BVALID_O       = bvalid_r;
   assign BRESP_O        = bresp_r;
   assign ARREADY_O      = !rvalid_r;
   assign RVALID_O       = rvalid_r;
   assign RRESP_O        = rresp_r;
   assign RDATA_O        = rdata_r;
   assign TX_VALID_O     = txv_r;
   assign TX_DATA_O      = beat_r.data;
   assign TX_GAP_O       = beat_r.gap;
   assign SYS_RESET_O    = sys_reset_r;
   assign ERASE_START_O  = erase_start_r;
   assign NVM_PROG_EN_O  = nvm_program_key_r && !NVM_LOCKED_I && NVM_PROG_READY_I;
   assign USER_ROW_EN_O  = user_row_write_key_r && NVM_LOCKED_I && USER_ROW_PROG_READY_I;
   assign SYSBUS_GRANT_O = SYSBUS_REQ_I && !NVM_LOCKED_I;
   assign SYSBUS_DENY_O  = SYSBUS_REQ_I && NVM_LOCKED_I;
endmodule : debug_key_sib_erase_logic
`default_nettype wire

// ===== rtl/gap_select.sv
`timescale 1ns/10ps
`default_nettype none
module gap_select
   import dbg_key_pkg::*;
(
   input  wire logic       first_i,
   input  wire logic       gap_en_i,
   input  wire logic [3:0] guard_i,
   output logic      [3:0] gap_o
);
   always_comb begin
      if (first_i) begin
         gap_o = guard_i;
      end else if (gap_en_i) begin
         gap_o = IDLE_BITS + GAP_EXTRA_BITS;
      end else begin
         gap_o = IDLE_BITS;
      end
   end
endmodule : gap_select
`default_nettype wire

// ===== rtl/key_matcher.sv
`timescale 1ns/10ps
`default_nettype none
module key_matcher
   import dbg_key_pkg::*;
(
   input  wire logic                clk_i,
   input  wire logic                rst_n_i,
   input  wire logic                byte_valid_i,
   input  wire logic [7:0]          byte_i,
   output logic      [NUM_KEYS-1:0] match_o
);
   logic [63:0] shift_r;
   logic [63:0] shift_nxt;

   // Least significant byte arrives first and ends in the low bits
   always_comb begin
      shift_nxt = shift_r;
      if (byte_valid_i) begin
         shift_nxt = {byte_i, shift_r[63:8]};
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         shift_r <= 64'h0;
      end else begin
         shift_r <= shift_nxt;
      end
   end

   genvar k;
   generate
      for (k = 0; k < NUM_KEYS; k++) begin : g_cmp
         assign match_o[k] = (shift_r == KEY_SIGS[k]);
      end
   endgenerate
endmodule : key_matcher
`default_nettype wire
